// *** src/thermal_defines.svh ***
/*
 Register addresses, field positions, reset values and fixed codes of the
 three-zone temperature monitor register bank.
 Assumes it is included by bare name after the package is compiled.
*/
`ifndef THERMAL_DEFINES_SVH
`define THERMAL_DEFINES_SVH

// Register addresses
`define ADDR_INT_HIGH_LEG  8'h00
`define ADDR_R1_HIGH_LEG   8'h01
`define ADDR_FLAGS         8'h02
`define ADDR_PRIMARY_RD    8'h03
`define ADDR_SECONDARY     8'h04
`define ADDR_PRIMARY_WR    8'h09
`define ADDR_ONE_SHOT      8'h0f
`define ADDR_R1_LOW_LEG    8'h10
`define ADDR_INT_LOW_LEG   8'h23
`define ADDR_R1_TRIM       8'h27
`define ADDR_R2_TRIM       8'h28
`define ADDR_PART_ID       8'hed
`define ADDR_R2_HIGH_LEG   8'hf8
`define ADDR_R2_LOW_LEG    8'hf9
`define ADDR_R1_HIGH_EXT   8'hfa
`define ADDR_R1_LOW_EXT    8'hfb
`define ADDR_R2_HIGH_EXT   8'hfc
`define ADDR_R2_LOW_EXT    8'hfd
`define ADDR_MAKER_ID      8'hfe
`define ADDR_REVISION      8'hff

// Reset values and writable-bit masks
`define RST_PRIMARY        8'h45
`define RST_SECONDARY      8'h08
`define RST_TRIM           8'h12
`define RST_RESULT         11'h000
`define MASK_PRIMARY       8'h47
`define MASK_SECONDARY     8'h0f
`define MASK_TRIM          8'h3f

// Field positions
`define BIT_STANDBY        6
`define BIT_MAX_RES        3
`define BIT_AVG_OFF        2
`define BIT_HOTTER_MODE    1
`define BIT_REC            0
`define BIT_BUSY           7
`define BIT_HOTTER         4
`define BIT_R2_FAULT       1
`define BIT_R1_FAULT       0

// Result codes in eighths of a degree
`define CODE_FAULT         11'h400
`define CODE_LEG_MIN       11'h600
`define CODE_LEG_MAX       11'h3ff
`define RAW_LEG_MIN        -13'sd512
`define RAW_LEG_MAX        13'sd1023
`define RAW_EXT_OFFSET     13'sd512
`define RAW_EXT_MIN        -13'sd1024
`define RAW_EXT_MAX        13'sd1023

`endif

// *** src/thermal_pkg.sv ***
/*
 Types shared by the register bank and its result capture channels.
 Assumes nothing of its surroundings.
*/
package thermal_pkg;
   typedef logic [7:0]         byte_t;
   typedef logic [10:0]        result_t;
   typedef logic signed [11:0] raw_t;
endpackage

// *** src/result_if.sv ***
/*
 Carrier between the register bank and one result capture channel.
 Assumes the bank drives the live value and the byte-read strobes.
*/
`timescale 1ns/1ns
interface result_if;
   import thermal_pkg::*;
   result_t live;
   logic    rd_high;
   logic    rd_low;
   byte_t   low_byte;
   modport bank (output live, output rd_high, output rd_low,
                 input low_byte);
   modport chan (input live, input rd_high, input rd_low,
                 output low_byte);
endinterface

// *** src/result_channel.sv ***
/*
 Low-byte interlock of one result (one channel in one format).
 Assumes read strobes are one-cycle pulses from the register bank.
*/
`timescale 1ns/1ns
`include "thermal_defines.svh"
module result_channel
   import thermal_pkg::*;
(
   input  wire logic clk_sys_i,
   input  wire logic nrst_i,
   result_if.chan    res
);
   logic [2:0] shadow_reg;
   logic       held_reg;

   // Capture on the high read, release on the low read
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         shadow_reg <= 3'h0;
         held_reg   <= 1'b0;
      end
      else if (res.rd_high)
      begin
         shadow_reg <= res.live[2:0];
         held_reg   <= 1'b1;
      end
      else if (res.rd_low)
         held_reg <= 1'b0;
   end

   // Fraction in bits 7..5, lower bits always zero
   assign res.low_byte = {held_reg ? shadow_reg : res.live[2:0], 5'h00};

   property p_capture;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      res.rd_high |=> held_reg && shadow_reg == $past(res.live[2:0]);
   endproperty
   a_capture: assert property (p_capture)
      else $error("low byte not captured on high read");

   property p_hold;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      held_reg && !res.rd_low && !res.rd_high |=>
         held_reg && $stable(shadow_reg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("captured low byte lost before low read");
endmodule

// *** src/thermal_regs.sv ***
/*
 Register bank of a three-zone temperature monitor: results, flags,
 setup, one-shot, ideality trims and identity.
 Assumes the serial protocol engine presents one-cycle read and write
 strobes with the register address byte, and that the conversion engine
 delivers raw results in eighths of a degree with a load pulse.
*/
`timescale 1ns/1ns
`include "thermal_defines.svh"
module thermal_regs
   import thermal_pkg::*;
#(
   parameter byte_t PART_CODE     = 8'ha5, // Arbitrary value
   parameter byte_t MAKER_CODE    = 8'h5a, // Arbitrary value
   parameter byte_t REVISION_CODE = 8'h0c  // Arbitrary value
)
(
   input  wire logic       clk_sys_i,
   input  wire logic       nrst_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_rd_i,
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   output      logic [7:0] reg_rdata_o,
   input  wire logic       result_load_i,
   input  wire raw_t       int_raw_i,
   input  wire raw_t       r1_raw_i,
   input  wire raw_t       r2_raw_i,
   input  wire logic       r1_fault_i,
   input  wire logic       r2_fault_i,
   input  wire logic       busy_i,
   input  wire logic       r2_hotter_i,
   output      logic       one_shot_o,
   output      logic       standby_o,
   output      logic [2:0] conv_rate_o,
   output      logic       max_res_o,
   output      logic       avg_off_o,
   output      logic       hotter_mode_o,
   output      logic       rec_enable_o,
   output      logic [5:0] r1_trim_o,
   output      logic [5:0] r2_trim_o
);
   // Channel order: internal, remote1, remote2 legacy; remote1, 2 extended
   localparam int NCH = 5;

   byte_t   primary_setup_reg, secondary_setup_reg;
   byte_t   remote1_ideality_trim_reg, remote2_ideality_trim_reg;
   result_t live_reg [NCH];
   logic    remote1_fault_flag_reg, remote2_fault_flag_reg;
   logic    one_shot_reg;
   byte_t   rdata_next;
   logic    addr_defined;
   logic    wr_primary, wr_secondary, wr_trim1, wr_trim2, wr_one_shot;
   logic    [NCH-1:0] rd_high_sel, rd_low_sel;
   byte_t   flags_value;

   result_if chan_if [NCH] ();

   // Clamp raw eighths to the legacy range; fault forces the fault code
   function automatic result_t to_legacy(input raw_t raw, input logic flt);
      logic signed [12:0] v;
      v = 13'(raw);
      if (flt)
         return `CODE_FAULT;
      else if (v < `RAW_LEG_MIN)
         return `CODE_LEG_MIN;
      else if (v > `RAW_LEG_MAX)
         return `CODE_LEG_MAX;
      else
         return v[10:0];
   endfunction

   // Offset by 64 degrees then clamp to the eleven-bit range
   function automatic result_t to_extended(input raw_t raw, input logic flt);
      logic signed [12:0] v;
      v = 13'(raw) - `RAW_EXT_OFFSET;
      if (flt)
         return `CODE_FAULT;
      else if (v < `RAW_EXT_MIN)
         return 11'h400;
      else if (v > `RAW_EXT_MAX)
         return 11'h3ff;
      else
         return v[10:0];
   endfunction

   // Write decode; undefined addresses match none of these
   assign wr_primary  = reg_wr_i && (reg_addr_i == `ADDR_PRIMARY_RD ||
                                     reg_addr_i == `ADDR_PRIMARY_WR);
   assign wr_secondary = reg_wr_i && reg_addr_i == `ADDR_SECONDARY;
   assign wr_trim1    = reg_wr_i && reg_addr_i == `ADDR_R1_TRIM;
   assign wr_trim2    = reg_wr_i && reg_addr_i == `ADDR_R2_TRIM;
   assign wr_one_shot = reg_wr_i && reg_addr_i == `ADDR_ONE_SHOT;

   // High and low byte read strobes per channel
   assign rd_high_sel = reg_rd_i ? {reg_addr_i == `ADDR_R2_HIGH_EXT,
                                    reg_addr_i == `ADDR_R1_HIGH_EXT,
                                    reg_addr_i == `ADDR_R2_HIGH_LEG,
                                    reg_addr_i == `ADDR_R1_HIGH_LEG,
                                    reg_addr_i == `ADDR_INT_HIGH_LEG}
                                 : 5'h00;
   assign rd_low_sel  = reg_rd_i ? {reg_addr_i == `ADDR_R2_LOW_EXT,
                                    reg_addr_i == `ADDR_R1_LOW_EXT,
                                    reg_addr_i == `ADDR_R2_LOW_LEG,
                                    reg_addr_i == `ADDR_R1_LOW_LEG,
                                    reg_addr_i == `ADDR_INT_LOW_LEG}
                                 : 5'h00;

   // Capture channels; each keeps its own interlock
   for (genvar i = 0; i < NCH; i++)
   begin : g_chan
      assign chan_if[i].live    = live_reg[i];
      assign chan_if[i].rd_high = rd_high_sel[i];
      assign chan_if[i].rd_low  = rd_low_sel[i];
      result_channel u_chan (
         .clk_sys_i (clk_sys_i),
         .nrst_i    (nrst_i),
         .res       (chan_if[i])
      );
   end

   // Hotter bit reads zero outside hotter-of-two mode
   assign flags_value = {busy_i, 2'b00,
                         r2_hotter_i & secondary_setup_reg[`BIT_HOTTER_MODE],
                         2'b00, remote2_fault_flag_reg,
                         remote1_fault_flag_reg};

   // Read selection by register address byte
   always_comb
   begin
      addr_defined = 1'b1;
      case (reg_addr_i)
         `ADDR_INT_HIGH_LEG: rdata_next = live_reg[0][10:3];
         `ADDR_R1_HIGH_LEG:  rdata_next = live_reg[1][10:3];
         `ADDR_R2_HIGH_LEG:  rdata_next = live_reg[2][10:3];
         `ADDR_R1_HIGH_EXT:  rdata_next = live_reg[3][10:3];
         `ADDR_R2_HIGH_EXT:  rdata_next = live_reg[4][10:3];
         `ADDR_INT_LOW_LEG:  rdata_next = chan_if[0].low_byte;
         `ADDR_R1_LOW_LEG:   rdata_next = chan_if[1].low_byte;
         `ADDR_R2_LOW_LEG:   rdata_next = chan_if[2].low_byte;
         `ADDR_R1_LOW_EXT:   rdata_next = chan_if[3].low_byte;
         `ADDR_R2_LOW_EXT:   rdata_next = chan_if[4].low_byte;
         `ADDR_FLAGS:        rdata_next = flags_value;
         `ADDR_PRIMARY_RD:   rdata_next = primary_setup_reg;
         `ADDR_SECONDARY:    rdata_next = secondary_setup_reg;
         `ADDR_ONE_SHOT:     rdata_next = 8'h00; // Nothing is stored
         `ADDR_R1_TRIM:      rdata_next = remote1_ideality_trim_reg;
         `ADDR_R2_TRIM:      rdata_next = remote2_ideality_trim_reg;
         `ADDR_PART_ID:      rdata_next = PART_CODE;
         `ADDR_MAKER_ID:     rdata_next = MAKER_CODE;
         `ADDR_REVISION:     rdata_next = REVISION_CODE;
         default:
         begin
            addr_defined = 1'b0;
            rdata_next   = 8'h00;
         end
      endcase
   end

   // Read data is held until the next read
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i)
         reg_rdata_o <= rdata_next;
   end

   // Host-writable setup; undefined addresses fall through untouched
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         primary_setup_reg         <= `RST_PRIMARY;
         secondary_setup_reg       <= `RST_SECONDARY;
         remote1_ideality_trim_reg <= `RST_TRIM;
         remote2_ideality_trim_reg <= `RST_TRIM;
      end
      else
      begin
         if (wr_primary)
            primary_setup_reg <= reg_wdata_i & `MASK_PRIMARY;
         if (wr_secondary)
            secondary_setup_reg <= reg_wdata_i & `MASK_SECONDARY;
         if (wr_trim1)
            remote1_ideality_trim_reg <= reg_wdata_i & `MASK_TRIM;
         if (wr_trim2)
            remote2_ideality_trim_reg <= reg_wdata_i & `MASK_TRIM;
      end
   end

   // One-shot is a single pulse; the written byte is dropped
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         one_shot_reg <= 1'b0;
      else
         one_shot_reg <= wr_one_shot;
   end

   // Results and fault flags refresh together on each load pulse
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         for (int i = 0; i < NCH; i++)
            live_reg[i] <= `RST_RESULT;
         remote1_fault_flag_reg <= 1'b0;
         remote2_fault_flag_reg <= 1'b0;
      end
      else if (result_load_i)
      begin
         live_reg[0] <= to_legacy(int_raw_i, 1'b0);
         live_reg[1] <= to_legacy(r1_raw_i, r1_fault_i);
         live_reg[2] <= to_legacy(r2_raw_i, r2_fault_i);
         live_reg[3] <= to_extended(r1_raw_i, r1_fault_i);
         live_reg[4] <= to_extended(r2_raw_i, r2_fault_i);
         remote1_fault_flag_reg <= r1_fault_i;
         remote2_fault_flag_reg <= r2_fault_i;
      end
   end

   // Setup fields out to the conversion engine
   assign one_shot_o    = one_shot_reg;
   assign standby_o     = primary_setup_reg[`BIT_STANDBY];
   assign conv_rate_o   = primary_setup_reg[2:0];
   assign max_res_o     = secondary_setup_reg[`BIT_MAX_RES];
   assign avg_off_o     = secondary_setup_reg[`BIT_AVG_OFF];
   assign hotter_mode_o = secondary_setup_reg[`BIT_HOTTER_MODE];
   assign rec_enable_o  = secondary_setup_reg[`BIT_REC];
   assign r1_trim_o     = remote1_ideality_trim_reg[5:0];
   assign r2_trim_o     = remote2_ideality_trim_reg[5:0];

   property p_reset_defaults;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      $rose(nrst_i) |-> primary_setup_reg == 8'h45 &&
         secondary_setup_reg == 8'h08 && remote2_ideality_trim_reg == 8'h12;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults)
      else $error("defaults not loaded at reset");

   property p_undef_read;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      reg_rd_i && !addr_defined |=> reg_rdata_o == 8'h00;
   endproperty
   a_undef_read: assert property (p_undef_read)
      else $error("undefined address read not zero");

   property p_undef_write;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      reg_wr_i && !addr_defined && reg_addr_i != 8'h09 |=>
         $stable(primary_setup_reg) && $stable(secondary_setup_reg) &&
         $stable(remote1_ideality_trim_reg) && !one_shot_o;
   endproperty
   a_undef_write: assert property (p_undef_write)
      else $error("undefined address write changed state");

   property p_one_shot;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      reg_wr_i && reg_addr_i == `ADDR_ONE_SHOT |=>
         one_shot_o ##1 (!one_shot_o || $past(wr_one_shot));
   endproperty
   a_one_shot: assert property (p_one_shot)
      else $error("one-shot pulse wrong");

   property p_low_zero;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      reg_rd_i && reg_addr_i == 8'h23 |=> reg_rdata_o[4:0] == 5'h00;
   endproperty
   a_low_zero: assert property (p_low_zero)
      else $error("legacy low byte spare bits not zero");

   // 64 degrees is the zero point of the extended format
   property p_ext_offset;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      result_load_i && !r1_fault_i && r1_raw_i == 12'sd512 |=>
         live_reg[3] == 11'h000;
   endproperty
   a_ext_offset: assert property (p_ext_offset)
      else $error("extended 64 degrees not at zero");

   property p_fault_flag;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      result_load_i |=>
         flags_value[1:0] == $past({r2_fault_i, r1_fault_i});
   endproperty
   a_fault_flag: assert property (p_fault_flag)
      else $error("remote fault flags wrong");
endmodule

// *** sim/conv_model.sv ***
/*
 Conversion engine stand-in: a one-shot pulse gives a busy span and one
 result load pulse.
 Assumes the bench drives the raw results and fault inputs itself.
*/
`timescale 1ns/1ns
module conv_model
#(
   parameter int CONV_CYCLES = 4
)
(
   input  wire logic clk_sys_i,
   input  wire logic nrst_i,
   input  wire logic start_i,
   output      logic busy_o,
   output      logic load_o
);
   int cnt;

   // A start during a conversion restarts it: one load follows, two if the start lands while cnt is 1
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt    <= 0;
         busy_o <= 1'b0;
         load_o <= 1'b0;
      end
      else
      begin
         cnt    <= start_i ? CONV_CYCLES : (cnt > 0 ? cnt - 1 : 0);
         busy_o <= start_i || cnt > 1;
         load_o <= (cnt == 1);
      end
   end
endmodule

// *** sim/thermal_regs_tb.sv ***
/*
 Self-checking bench of the register bank: defaults, refusals, setup
 fields, result formats, flags and the low-byte lock.
 Assumes the package, the defines header and the design are compiled.
*/
`timescale 1ns/1ns
`include "thermal_defines.svh"
module thermal_regs_tb
   import thermal_pkg::*;
;
   localparam byte_t PART_V     = 8'h3c; // Arbitrary value
   localparam byte_t MAKER_V    = 8'hc3; // Arbitrary value
   localparam byte_t REVISION_V = 8'h07; // Arbitrary value
   localparam byte_t HI_A [5] = '{`ADDR_INT_HIGH_LEG, `ADDR_R1_HIGH_LEG,
      `ADDR_R2_HIGH_LEG, `ADDR_R1_HIGH_EXT, `ADDR_R2_HIGH_EXT};
   localparam byte_t LO_A [5] = '{`ADDR_INT_LOW_LEG, `ADDR_R1_LOW_LEG,
      `ADDR_R2_LOW_LEG, `ADDR_R1_LOW_EXT, `ADDR_R2_LOW_EXT};
   localparam byte_t DF_A [9] = '{`ADDR_PRIMARY_RD, `ADDR_SECONDARY,
      `ADDR_R1_TRIM, `ADDR_R2_TRIM, `ADDR_FLAGS, `ADDR_PART_ID,
      `ADDR_MAKER_ID, `ADDR_REVISION, `ADDR_ONE_SHOT};
   localparam byte_t DF_D [9] = '{8'h45, 8'h08, 8'h12, 8'h12, 8'h00,
      PART_V, MAKER_V, REVISION_V, 8'h00};
   localparam byte_t UD_A [4] = '{8'h05, 8'h0a, 8'h11, 8'hee};
   // Clamp edges of both formats except the extended minimum, and both fault flags
   localparam raw_t  RS [4][3] = '{'{204, -82, 1200}, '{-600, 1700, -8},
      '{1023, -1200, 511}, '{-512, 512, -1100}};
   localparam logic  F1 [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
   localparam logic  F2 [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

   logic       clk_sys_i, nrst_i, reg_rd_i, reg_wr_i;
   logic       r1_fault_i, r2_fault_i, r2_hotter_i;
   byte_t      reg_addr_i, reg_wdata_i, reg_rdata_o, setup_bits;
   raw_t       int_raw_i, r1_raw_i, r2_raw_i;
   logic       busy_i, result_load_i, one_shot_o, standby_o, max_res_o;
   logic       avg_off_o, hotter_mode_o, rec_enable_o;
   logic [2:0] conv_rate_o;
   logic [5:0] r1_trim_o, r2_trim_o;
   result_t    c;
   int         errors = 0;
   int         comparisons = 0;

   // Setup fields packed in primary then secondary order
   assign setup_bits = {standby_o, conv_rate_o, max_res_o, avg_off_o,
                        hotter_mode_o, rec_enable_o};

   thermal_regs
   #(
      .PART_CODE     (PART_V),
      .MAKER_CODE    (MAKER_V),
      .REVISION_CODE (REVISION_V)
   )
   dut
   (
      .clk_sys_i     (clk_sys_i),
      .nrst_i        (nrst_i),
      .reg_addr_i    (reg_addr_i),
      .reg_rd_i      (reg_rd_i),
      .reg_wr_i      (reg_wr_i),
      .reg_wdata_i   (reg_wdata_i),
      .reg_rdata_o   (reg_rdata_o),
      .result_load_i (result_load_i),
      .int_raw_i     (int_raw_i),
      .r1_raw_i      (r1_raw_i),
      .r2_raw_i      (r2_raw_i),
      .r1_fault_i    (r1_fault_i),
      .r2_fault_i    (r2_fault_i),
      .busy_i        (busy_i),
      .r2_hotter_i   (r2_hotter_i),
      .one_shot_o    (one_shot_o),
      .standby_o     (standby_o),
      .conv_rate_o   (conv_rate_o),
      .max_res_o     (max_res_o),
      .avg_off_o     (avg_off_o),
      .hotter_mode_o (hotter_mode_o),
      .rec_enable_o  (rec_enable_o),
      .r1_trim_o     (r1_trim_o),
      .r2_trim_o     (r2_trim_o)
   );

   conv_model u_conv
   (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .start_i   (one_shot_o),
      .busy_o    (busy_i),
      .load_o    (result_load_i)
   );

   // 100 MHz system clock
   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic give_verdict();
      if (errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(byte_t seen, byte_t exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Read data lands on the edge that takes the strobe
   task automatic rdc(byte_t a, byte_t e);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i   <= 1'b0;
      #1 check(reg_rdata_o, e);
   endtask

   // Every write also proves the one-shot pulse is one cycle, 0Fh only
   task automatic wr(byte_t a, byte_t d);
      @(posedge clk_sys_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i    <= 1'b0;
      #1 check({7'h00, one_shot_o}, {7'h00, a == `ADDR_ONE_SHOT});
      @(posedge clk_sys_i);
      #1 check({7'h00, one_shot_o}, 8'h00);
   endtask

   task automatic do_reset();
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
   endtask

   task automatic defaults();
      do_reset();
      for (int i = 0; i < 9; i++)
         rdc(DF_A[i], DF_D[i]);
      for (int i = 0; i < 5; i++)
      begin
         rdc(HI_A[i], 8'h00);
         rdc(LO_A[i], 8'h00);
      end
      check(setup_bits, 8'hd8);
      check({r1_trim_o, r2_trim_o[5:4]}, 8'h49);
      check({2'b00, r2_trim_o}, 8'h12);
   endtask

   // Expected code from the raw inputs held since the last load
   function automatic result_t code(int ch);
      logic signed [12:0] v;
      int                 lo;
      lo = (ch > 2) ? -1024 : -512;
      v = (ch == 0) ? int_raw_i : (ch % 2) ? r1_raw_i : r2_raw_i;
      if (ch > 0 && ((ch % 2) ? r1_fault_i : r2_fault_i))
         return 11'h400;
      if (ch > 2)
         v = v - 13'sd512;
      if (v < lo)
         v = lo;
      if (v > 1023)
         v = 1023;
      return v[10:0];
   endfunction

   task automatic convert(raw_t a, raw_t b, raw_t d, logic f1, logic f2);
      logic [1:0] old_flags;
      old_flags = {r2_fault_i, r1_fault_i};
      @(posedge clk_sys_i);
      {int_raw_i, r1_raw_i, r2_raw_i} <= {a, b, d};
      {r1_fault_i, r2_fault_i} <= {f1, f2};
      wr(`ADDR_ONE_SHOT, 8'h5c);
      // Busy shows mid-conversion; fault bits are still the last load's
      rdc(`ADDR_FLAGS, {1'b1, 5'h00, old_flags});
      for (int i = 0; i < 20 && result_load_i !== 1'b1; i++)
         @(posedge clk_sys_i) #1;
      check({7'h00, result_load_i}, 8'h01);
   endtask

   // Reading high then low of each result also releases each lock
   task automatic chk_all();
      result_t v;
      for (int i = 0; i < 5; i++)
      begin
         v = code(i);
         rdc(HI_A[i], v[10:3]);
         rdc(LO_A[i], {v[2:0], 5'h00});
      end
      rdc(`ADDR_FLAGS, {6'h00, r2_fault_i, r1_fault_i});
   endtask

   initial
   begin
      {nrst_i, reg_rd_i, reg_wr_i, r1_fault_i, r2_fault_i} = '0;
      {r2_hotter_i, reg_addr_i, reg_wdata_i} = '0;
      {int_raw_i, r1_raw_i, r2_raw_i} = '0;
      defaults();
      // Setup fields, reserved bits dropped, refused places
      wr(`ADDR_PRIMARY_WR, 8'hff);
      rdc(`ADDR_PRIMARY_RD, 8'h47);
      check(setup_bits, 8'hf8);
      for (int i = 0; i < 4; i++)
      begin
         rdc(UD_A[i], 8'h00);
         wr(UD_A[i], 8'hff);
      end
      wr(`ADDR_R1_HIGH_LEG, 8'hff);
      rdc(`ADDR_R1_HIGH_LEG, 8'h00);
      rdc(`ADDR_PRIMARY_RD, 8'h47);
      rdc(`ADDR_SECONDARY, 8'h08);
      rdc(`ADDR_R1_TRIM, 8'h12);
      wr(`ADDR_PRIMARY_RD, 8'h00);
      wr(`ADDR_SECONDARY, 8'hff);
      check(setup_bits, 8'h0f);
      rdc(`ADDR_SECONDARY, 8'h0f);
      wr(`ADDR_R1_TRIM, 8'hff);
      wr(`ADDR_R2_TRIM, 8'hd5);
      check({r1_trim_o, r2_trim_o[5:4]}, 8'hfd);
      check({2'b00, r2_trim_o}, 8'h15);
      rdc(`ADDR_R1_TRIM, 8'h3f);
      defaults();
      // Result formats, clamps and faults over several conversions
      for (int i = 0; i < 4; i++)
      begin
         convert(RS[i][0], RS[i][1], RS[i][2], F1[i], F2[i]);
         chk_all();
      end
      // Hotter flag shows only in hotter mode
      wr(`ADDR_SECONDARY, 8'h02);
      @(posedge clk_sys_i) r2_hotter_i <= 1'b1;
      rdc(`ADDR_FLAGS, 8'h12);
      wr(`ADDR_SECONDARY, 8'h00);
      rdc(`ADDR_FLAGS, 8'h02);
      // Lock the remote-1 legacy low byte, then convert underneath it
      convert(12'sd40, -12'sd82, 12'sd8, 1'b0, 1'b0);
      c = code(1);
      rdc(`ADDR_R1_HIGH_LEG, c[10:3]);
      convert(12'sd40, 12'sd1700, 12'sd8, 1'b0, 1'b0);
      rdc(`ADDR_R1_LOW_EXT, 8'he0);
      rdc(`ADDR_R1_LOW_LEG, {c[2:0], 5'h00});
      rdc(`ADDR_R1_LOW_LEG, 8'he0);
      give_verdict();
   end

   // Whole sequence needs well under this span
   initial
   begin
      #100000;
      errors++;
      give_verdict();
   end
endmodule
